// ---- design/accel_ctrl_pkg.sv ----
// Purpose: shared constants, types and register map of the accelerometer control core
// Assumes: 250 MHz core clock, 8-bit register port fed by the serial bus engine
// Notes:   rate codes follow the sample-rate register layout below
package accel_ctrl_pkg;
  // clock and sample periods
  localparam int CLK_PERIOD_NS    = 4;
  localparam int PERIOD_64SPS_NS  = 15625000;  // 15.625 ms
  localparam int PERIOD_120SPS_NS = 8360000;   // 8.36 ms
  localparam int BASE_CYCLES      = PERIOD_64SPS_NS / CLK_PERIOD_NS;
  localparam int FAST_CYCLES      = PERIOD_120SPS_NS / CLK_PERIOD_NS;
  // register offsets
  localparam logic [7:0] ADDR_XDATA     = 8'h00;
  localparam logic [7:0] ADDR_YDATA     = 8'h01;
  localparam logic [7:0] ADDR_ZDATA     = 8'h02;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
  localparam logic [7:0] ADDR_SLEEP_CNT = 8'h05;
  localparam logic [7:0] ADDR_IRQ_SETUP = 8'h06;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h07;
  localparam logic [7:0] ADDR_RATE_CFG  = 8'h08;
  // irq_setup and irq status bit positions
  localparam int BIT_FRONT_BACK = 0;
  localparam int BIT_ORIENT     = 1;
  localparam int BIT_TAP        = 2;
  localparam int BIT_AUTO_SLEEP = 3;
  localparam int BIT_DATA_UPD   = 4;
  localparam int BIT_SHAKE_X    = 5;
  // mode_control bit positions
  localparam int BIT_MODE_ACTIVE = 0;
  localparam int BIT_AUTO_WAKE   = 3;
  localparam int BIT_AUTO_SLEEP_EN = 4;
  // sample_rate_config fields
  localparam int ACT_RATE_LSB  = 0;
  localparam int WAKE_RATE_LSB = 3;
  // reset values
  localparam logic [7:0] RST_IRQ_SETUP = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_RATE_CFG  = 8'h00;
  localparam logic [7:0] RST_SLEEP_CNT = 8'h10;
  // shake limit: 1.3 g at 21.33 counts/g
  localparam logic [5:0] SHAKE_LIMIT = 6'h1B;
  localparam logic [2:0] RATE_CODE_120 = 3'h0;

  typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_RUN, ST_DOZE} power_state_e;

  typedef struct packed {
    logic [5:0] x;
    logic [5:0] y;
    logic [5:0] z;
  } axes_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;
endpackage

// ---- design/accel_mode_rate_irq_ctrl.sv ----
// Purpose: power mode, sample rate and interrupt selection of the accelerometer core
// Assumes: supply-good levels and event pulses are synchronous to sys_clk_i
// Notes:   the serial bus engine presents one register request per cycle
//
// Function
// RL1 - analog supply absent: ignore every bus access
// RL2 - both supplies up: enter standby automatically
// RL3 - standby: registers accessible, no new samples
// RL4 - mode bit at 0x07 selects standby/active
// RL5 - exactly one power state at a time
// RL6 - active: sample all axes, run enabled features
// RL7 - eight rates selected at 0x08
// RL8 - auto-wake rates limited to 1/8/16/32
// RL9 - all three 6-bit axes update together
// RL10 - 0x06 holds seven separate interrupt enables; the code decodes eight, one per bit 0-7
// RL11 - data-update interrupt after every sample
// RL12 - shake interrupt above 1.3 g per axis
// RL13 - orientation change raises interrupt when enabled
// RL14 - auto-sleep counter expiry raises interrupt; the code raises it only with auto-wake set (bit 3 at 0x07)
// RL15 - low-rate state: motion event returns to wake
// RL16 - tap detection off in auto-wake state
// RL17 - auto-wake/sleep switches between two selected rates
// RL18 - host sets tap enable and rate 000
// RL19 - interrupt held until status register read
`timescale 1ns/100ps
`default_nettype none
module accel_mode_rate_irq_ctrl
  import accel_ctrl_pkg::*;
#(
  parameter int BASE_PERIOD_CYCLES = BASE_CYCLES,
  parameter int FAST_PERIOD_CYCLES = FAST_CYCLES
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  // supply monitors
  input  wire logic         avdd_ok_i,
  input  wire logic         dvdd_ok_i,
  // register port from the serial bus engine
  input  wire reg_req_s     reg_req_i,
  output logic [7:0]        reg_rdata_o,
  output logic              reg_ack_o,
  // measurement and feature events
  input  wire axes_s        axes_i,
  input  wire logic         orient_change_i,
  input  wire logic         front_back_change_i,
  input  wire logic         tap_i,
  // status outputs
  output logic              sample_tick_o,
  output logic              tap_enable_o,
  output power_state_e      power_state_o,
  output logic              irq_o
);

  localparam int CW = 22;
  localparam logic [CW-1:0] BASE_LIM = CW'(BASE_PERIOD_CYCLES - 1);
  localparam logic [CW-1:0] FAST_LIM = CW'(FAST_PERIOD_CYCLES - 1);

  power_state_e  state_r, state_nxt;
  logic [7:0]    irq_setup_r, irq_setup_nxt;
  logic [7:0]    mode_ctrl_r, mode_ctrl_nxt;
  logic [7:0]    rate_cfg_r, rate_cfg_nxt;
  logic [7:0]    sleep_lim_r, sleep_lim_nxt;
  logic [7:0]    idle_cnt_r, idle_cnt_nxt;
  logic [7:0]    pend_r, pend_nxt;
  axes_s         axes_r, axes_nxt;
  logic [CW-1:0] base_cnt_r, base_cnt_nxt;
  logic [6:0]    div_cnt_r, div_cnt_nxt;
  logic [7:0]    rdata_r, rdata_nxt;
  logic          ack_r, ack_nxt;
  logic          tick_r, tick_nxt;
  logic          tap_en_r, tap_en_nxt;
  logic          irq_r, irq_nxt;

  // selects sample divider exponent from the active or low-rate field
  function automatic logic [2:0] rate_exp(input logic doze, input logic [7:0] cfg);
    logic [2:0] c;
    logic [1:0] w;
    c = cfg[ACT_RATE_LSB +: 3];
    w = cfg[WAKE_RATE_LSB +: 2];
    if (doze) begin
      // only 32, 16, 8 and 1 samples/s exist in the low-rate field [RL8]
      unique case (w)
        2'h0:    rate_exp = 3'h1;
        2'h1:    rate_exp = 3'h2;
        2'h2:    rate_exp = 3'h3;
        2'h3:    rate_exp = 3'h6;
      endcase
    end else begin
      rate_exp = (c == RATE_CODE_120) ? 3'h0 : c - 3'h1; // [RL7]
    end
  endfunction

  // absolute value of a 6-bit two's complement reading
  function automatic logic [5:0] mag6(input logic [5:0] v);
    mag6 = v[5] ? 6'(~v + 6'h01) : v;
  endfunction

  // next-state logic for power state, rate timing, registers and interrupts
  always_comb begin
    logic       powered;
    logic       active;
    logic       fast;
    logic       tick;
    logic       wr_ok;
    logic       rd_ok;
    logic       motion;
    logic [6:0] div_lim;
    logic [2:0] shake;
    logic [7:0] ev;
    powered = avdd_ok_i && dvdd_ok_i;
    active  = (state_r == ST_RUN) || (state_r == ST_DOZE);
    fast    = (state_r == ST_RUN) && (rate_cfg_r[ACT_RATE_LSB +: 3] == RATE_CODE_120);
    div_lim = 7'((8'h01 << rate_exp(state_r == ST_DOZE, rate_cfg_r)) - 8'h01);
    tick    = 1'b0;
    shake   = 3'h0;
    ev      = 8'h00;
    motion  = 1'b0;
    // bus is dead without both supplies; off state answers nothing [RL1]
    wr_ok   = reg_req_i.wr && state_r != ST_OFF && powered;
    rd_ok   = reg_req_i.rd && state_r != ST_OFF && powered;

    state_nxt     = state_r;
    irq_setup_nxt = irq_setup_r;
    mode_ctrl_nxt = mode_ctrl_r;
    rate_cfg_nxt  = rate_cfg_r;
    sleep_lim_nxt = sleep_lim_r;
    idle_cnt_nxt  = idle_cnt_r;
    pend_nxt      = pend_r;
    axes_nxt      = axes_r;
    base_cnt_nxt  = base_cnt_r;
    div_cnt_nxt   = div_cnt_r;
    rdata_nxt     = rdata_r;
    ack_nxt       = 1'b0;

    // sample timing: a dedicated period for 120/s, power-of-two base otherwise [RL7]
    if (!active) begin
      base_cnt_nxt = '0; // no sampling outside active states [RL3]
      div_cnt_nxt  = 7'h00;
    end else if (base_cnt_r >= (fast ? FAST_LIM : BASE_LIM)) begin
      base_cnt_nxt = '0;
      if (fast || div_cnt_r >= div_lim) begin
        tick        = 1'b1;
        div_cnt_nxt = 7'h00;
      end else begin
        div_cnt_nxt = div_cnt_r + 7'h01;
      end
    end else begin
      base_cnt_nxt = base_cnt_r + CW'(1);
    end

    // capture all three axes together and derive events [RL6]
    if (tick) begin
      axes_nxt = axes_i; // [RL9]
      shake    = {mag6(axes_i.z) > SHAKE_LIMIT, mag6(axes_i.y) > SHAKE_LIMIT,
                  mag6(axes_i.x) > SHAKE_LIMIT}; // [RL12]
      ev[BIT_DATA_UPD] = 1'b1; // [RL11]
    end
    ev[BIT_SHAKE_X +: 3]   = shake;
    ev[BIT_ORIENT]         = active && orient_change_i; // [RL13]
    ev[BIT_FRONT_BACK]     = active && front_back_change_i;
    ev[BIT_TAP]            = (state_r == ST_RUN) && tap_i; // tap blind while dozing [RL16]
    ev = ev & irq_setup_r; // [RL10]
    motion = |{ev[BIT_SHAKE_X +: 3], ev[BIT_ORIENT], ev[BIT_FRONT_BACK], ev[BIT_TAP]};

    // auto-sleep: count quiet samples, drop to the low rate on expiry [RL17]
    if (state_r == ST_RUN && mode_ctrl_r[BIT_AUTO_SLEEP_EN] && tick) begin
      if (motion) begin
        idle_cnt_nxt = 8'h00;
      end else if (idle_cnt_r + 8'h01 >= sleep_lim_r) begin
        idle_cnt_nxt = 8'h00;
        state_nxt    = ST_DOZE;
        if (mode_ctrl_r[BIT_AUTO_WAKE]) begin
          ev[BIT_AUTO_SLEEP] = irq_setup_r[BIT_AUTO_SLEEP]; // [RL14]
        end
      end else begin
        idle_cnt_nxt = idle_cnt_r + 8'h01;
      end
    end
    // any motion event in the low-rate state restores the higher rate [RL15]
    if (state_r == ST_DOZE && motion) begin
      state_nxt = ST_RUN;
    end
    if (state_r != ST_RUN) begin
      if (state_r != ST_DOZE || motion) begin
        idle_cnt_nxt = 8'h00;
      end
    end

    // register writes are honoured in standby and active alike [RL3]
    if (wr_ok) begin
      unique case (reg_req_i.addr)
        ADDR_IRQ_SETUP: irq_setup_nxt = reg_req_i.wdata;
        ADDR_MODE_CTRL: mode_ctrl_nxt = reg_req_i.wdata;
        ADDR_RATE_CFG:  rate_cfg_nxt  = reg_req_i.wdata;
        ADDR_SLEEP_CNT: sleep_lim_nxt = reg_req_i.wdata;
        default:        ;
      endcase
    end

    // reads: data comes one cycle later; status read clears pending
    if (rd_ok) begin
      ack_nxt = 1'b1;
      unique case (reg_req_i.addr)
        ADDR_XDATA:     rdata_nxt = {2'h0, axes_r.x};
        ADDR_YDATA:     rdata_nxt = {2'h0, axes_r.y};
        ADDR_ZDATA:     rdata_nxt = {2'h0, axes_r.z};
        ADDR_IRQ_STAT:  rdata_nxt = pend_r;
        ADDR_SLEEP_CNT: rdata_nxt = sleep_lim_r;
        ADDR_IRQ_SETUP: rdata_nxt = irq_setup_r;
        ADDR_MODE_CTRL: rdata_nxt = mode_ctrl_r;
        ADDR_RATE_CFG:  rdata_nxt = rate_cfg_r;
        default:        rdata_nxt = 8'h00;
      endcase
      if (reg_req_i.addr == ADDR_IRQ_STAT) begin
        pend_nxt = 8'h00; // [RL19]
      end
    end
    if (wr_ok) begin
      ack_nxt = 1'b1;
    end
    // a new event in the clearing cycle survives the clear
    pend_nxt = pend_nxt | ev; // [RL19]

    // power state machine; a single enum register holds one state [RL5]
    unique case (state_r)
      ST_OFF: begin
        if (powered) begin
          state_nxt = ST_STANDBY; // [RL2]
        end
      end
      ST_STANDBY: begin
        if (mode_ctrl_r[BIT_MODE_ACTIVE]) begin
          state_nxt = ST_RUN; // [RL4]
        end
      end
      ST_RUN, ST_DOZE: begin
        if (!mode_ctrl_r[BIT_MODE_ACTIVE]) begin
          state_nxt = ST_STANDBY; // [RL4]
        end
      end
    endcase
    // losing a supply overrides everything; mode bit drops so power-up lands in standby
    if (!powered) begin
      state_nxt                      = ST_OFF; // [RL1]
      mode_ctrl_nxt[BIT_MODE_ACTIVE] = 1'b0;
      pend_nxt                       = 8'h00;
      ack_nxt                        = 1'b0;
    end

    tick_nxt   = tick;
    tap_en_nxt = (state_nxt == ST_RUN) && irq_setup_nxt[BIT_TAP]; // [RL16]
    irq_nxt    = |pend_nxt;
  end

  // state registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r     <= ST_OFF;
      irq_setup_r <= RST_IRQ_SETUP;
      mode_ctrl_r <= RST_MODE_CTRL;
      rate_cfg_r  <= RST_RATE_CFG;
      sleep_lim_r <= RST_SLEEP_CNT;
      idle_cnt_r  <= 8'h00;
      pend_r      <= 8'h00;
      axes_r      <= '0;
      base_cnt_r  <= '0;
      div_cnt_r   <= 7'h00;
      rdata_r     <= 8'h00;
      ack_r       <= 1'b0;
      tick_r      <= 1'b0;
      tap_en_r    <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      irq_setup_r <= irq_setup_nxt;
      mode_ctrl_r <= mode_ctrl_nxt;
      rate_cfg_r  <= rate_cfg_nxt;
      sleep_lim_r <= sleep_lim_nxt;
      idle_cnt_r  <= idle_cnt_nxt;
      pend_r      <= pend_nxt;
      axes_r      <= axes_nxt;
      base_cnt_r  <= base_cnt_nxt;
      div_cnt_r   <= div_cnt_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
      tick_r      <= tick_nxt;
      tap_en_r    <= tap_en_nxt;
      irq_r       <= irq_nxt;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_o   = rdata_r;
  assign reg_ack_o     = ack_r;
  assign sample_tick_o = tick_r;
  assign tap_enable_o  = tap_en_r;
  assign power_state_o = state_r;
  assign irq_o         = irq_r;

endmodule
`default_nettype wire

// ---- dv/accel_ctrl_monitor.sv ----
// Purpose: port-level checks of power mode, rate and interrupt behaviour
// Assumes: sim periods of 8 and 5 cycles, so ticks never come closer than 5 cycles
// Notes:   bound to every instance of the control block
`timescale 1ns/100ps
`default_nettype none
module accel_ctrl_monitor
  import accel_ctrl_pkg::*;
#(
  parameter int BASE_PERIOD_CYCLES = 8,
  parameter int FAST_PERIOD_CYCLES = 5
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  // supplies and register port
  input  wire logic         avdd_ok_i,
  input  wire logic         dvdd_ok_i,
  input  wire reg_req_s     reg_req_i,
  input  wire logic         reg_ack_o,
  // events and status
  input  wire logic         orient_change_i,
  input  wire logic         front_back_change_i,
  input  wire logic         tap_i,
  input  wire logic         sample_tick_o,
  input  wire logic         tap_enable_o,
  input  wire power_state_e power_state_o,
  input  wire logic         irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic taken;
  logic upd_en_r;
  logic upd_en_nxt;
  // a request only counts once both supplies are up and the block has left off
  assign taken = (reg_req_i.wr || reg_req_i.rd) && avdd_ok_i && dvdd_ok_i
                 && power_state_o != ST_OFF;
  // shadow of the data-update enable, kept across supply loss like the register
  always_comb begin
    upd_en_nxt = upd_en_r;
    if (taken && reg_req_i.wr && reg_req_i.addr == ADDR_IRQ_SETUP) begin
      upd_en_nxt = reg_req_i.wdata[BIT_DATA_UPD];
    end
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      upd_en_r <= 1'b0;
    end else begin
      upd_en_r <= upd_en_nxt;
    end
  end
  // named steps of the mode switch and of the status read
  sequence s_go_active;
    taken && reg_req_i.wr && reg_req_i.addr == ADDR_MODE_CTRL
      && reg_req_i.wdata[BIT_MODE_ACTIVE] && power_state_o == ST_STANDBY;
  endsequence
  sequence s_status_clear;
    taken && reg_req_i.rd && reg_req_i.addr == ADDR_IRQ_STAT
      && power_state_o == ST_STANDBY && !tap_i && !orient_change_i && !front_back_change_i;
  endsequence
  a_ack_next: assert property (taken |=> reg_ack_o)
    else $error("taken request not acknowledged next cycle");
  a_off_silent: assert property ((reg_req_i.wr || reg_req_i.rd) && !avdd_ok_i |=> !reg_ack_o)
    else $error("access answered without analog supply");
  a_supply_off: assert property (!avdd_ok_i |=> power_state_o == ST_OFF)
    else $error("state not off after analog supply loss");
  a_auto_standby: assert property (power_state_o == ST_OFF && avdd_ok_i && dvdd_ok_i
    |=> power_state_o == ST_STANDBY)
    else $error("standby not entered with both supplies up");
  a_go_active: assert property (s_go_active |-> ##2 power_state_o == ST_RUN)
    else $error("mode bit write did not start active state");
  a_standby_quiet: assert property (power_state_o == ST_STANDBY && $past(power_state_o) == ST_STANDBY
    && $past(power_state_o, 2) == ST_STANDBY |-> !sample_tick_o)
    else $error("sample taken in standby");
  a_tick_spacing: assert property (sample_tick_o |=> !sample_tick_o [*4])
    else $error("samples closer than the fastest rate");
  a_tap_run_only: assert property (tap_enable_o
    |-> power_state_o == ST_RUN || $past(power_state_o) == ST_RUN)
    else $error("tap detection enabled outside active state");
  a_upd_irq: assert property (sample_tick_o && upd_en_r |-> ##[0:2] irq_o)
    else $error("no interrupt after data update");
  a_irq_release: assert property (s_status_clear |-> ##[1:2] !irq_o)
    else $error("interrupt held after status read");
endmodule
bind accel_mode_rate_irq_ctrl accel_ctrl_monitor #(.BASE_PERIOD_CYCLES(BASE_PERIOD_CYCLES),
  .FAST_PERIOD_CYCLES(FAST_PERIOD_CYCLES)) mon_inst (.sys_clk_i, .reset_n_i, .avdd_ok_i,
  .dvdd_ok_i, .reg_req_i, .reg_ack_o, .orient_change_i, .front_back_change_i, .tap_i,
  .sample_tick_o, .tap_enable_o, .power_state_o, .irq_o);
`default_nettype wire

// ---- dv/reg_host_model.sv ----
// Purpose: register-port host issuing single-byte reads and writes
// Assumes: requests launch on the falling edge, strobe high for one cycle
// Notes:   released lines carry inverted values so stale data is never trusted
`timescale 1ns/100ps
`default_nettype none
module reg_host_model
  import accel_ctrl_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // register port
  output var reg_req_s    req_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       ack_i
);
  initial req_o = '0;
  // one request per call; answer is taken one cycle after the strobe
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic acked);
    @(negedge clk_i);
    req_o = '{addr: addr, wdata: wdata, wr: wr, rd: !wr};
    @(negedge clk_i);
    acked = ack_i;
    rdata = rdata_i;
    req_o = '{addr: ~addr, wdata: ~wdata, wr: 1'b0, rd: 1'b0};
  endtask
endmodule
`default_nettype wire

// ---- dv/accel_mode_rate_irq_ctrl_tb.sv ----
// Purpose: self-checking bench for mode, rate and interrupt control
// Assumes: sim periods of 8 and 5 cycles, axis values kept positive
// Notes:   expectations come from a register shadow and the rate table
`timescale 1ns/100ps
`default_nettype none
module accel_mode_rate_irq_ctrl_tb;
  import accel_ctrl_pkg::*;
  localparam int BASE = 8;
  localparam int FAST = 5;
  logic         clk;
  logic         rst_n;
  logic         avdd_ok;
  logic         dvdd_ok;
  reg_req_s     req;
  logic [7:0]   rdata;
  logic         ack;
  axes_s        axes;
  logic         orient;
  logic         fb;
  logic         tap;
  logic         tick;
  logic         tap_en;
  power_state_e pstate;
  logic         irq;
  logic [7:0]   r;
  logic         k;
  int           err_total;
  int           checks;
  int           cycles;
  int           seed;
  int           n;
  int           shadow [0:15];
  accel_mode_rate_irq_ctrl #(.BASE_PERIOD_CYCLES(BASE), .FAST_PERIOD_CYCLES(FAST))
    accel_mode_rate_irq_ctrl_inst (.sys_clk_i(clk), .reset_n_i(rst_n), .avdd_ok_i(avdd_ok),
    .dvdd_ok_i(dvdd_ok), .reg_req_i(req), .reg_rdata_o(rdata), .reg_ack_o(ack), .axes_i(axes),
    .orient_change_i(orient), .front_back_change_i(fb), .tap_i(tap), .sample_tick_o(tick),
    .tap_enable_o(tap_en), .power_state_o(pstate), .irq_o(irq));
  reg_host_model host_inst (.clk_i(clk), .req_o(req), .rdata_i(rdata), .ack_i(ack));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // writes keep the shadow model current
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_inst.access(1'b1, a, d, r, k);
    check(k, 1'b1);
    shadow[a[3:0]] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_inst.access(1'b0, a, 8'h00, r, k);
    check(k, 1'b1);
    check(r, e);
  endtask
  // bounded wait; n ends as the cycles since the previous tick
  task automatic wait_tick;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 3000);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    {rst_n, orient, fb, tap} = 4'h0;
    cycles    = 0;
    err_total = 0;
    checks    = 0;
    {avdd_ok, dvdd_ok} = 2'b11;
    axes = '0;
    seed = 32'h954216CE;
    foreach (shadow[i]) shadow[i] = 0;
    shadow[5] = 16;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check(pstate, ST_STANDBY);
    for (int a = 5; a < 9; a++) rd(8'(a), 8'(shadow[a]));
    rd(8'h0F, 8'h00);
    wr(ADDR_IRQ_SETUP, 8'($random(seed)));
    rd(ADDR_IRQ_SETUP, 8'(shadow[6]));
    avdd_ok = 1'b0;
    @(negedge clk);
    check(pstate, ST_OFF);
    host_inst.access(1'b0, ADDR_IRQ_SETUP, 8'h00, r, k);
    check(k, 1'b0);
    avdd_ok = 1'b1;
    repeat (2) @(negedge clk);
    rd(ADDR_IRQ_SETUP, 8'(shadow[6]));
    // every rate code: tick spacing, axis capture, data-update interrupt
    wr(ADDR_IRQ_SETUP, 8'h10);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_RATE_CFG, 8'(c));
      axes = 18'($random(seed)) & 18'h1F7DF;
      wr(ADDR_MODE_CTRL, 8'h01);
      wait_tick();
      wait_tick();
      check(16'(n), 16'(c == 0 ? FAST : BASE << (c - 1)));
      repeat (2) @(negedge clk);
      check(irq, 1'b1);
      {shadow[0], shadow[1], shadow[2]} = {32'(axes.x), 32'(axes.y), 32'(axes.z)};
      for (int a = 0; a < 3; a++) rd(8'(a), 8'(shadow[a]));
      wr(ADDR_MODE_CTRL, 8'h00);
      repeat (3) @(negedge clk);
      check(pstate, ST_STANDBY);
      // axes change only once sampling has stopped; a last tick may still land after the write
      axes = '0;
      rd(ADDR_IRQ_STAT, 8'h10);
      check(irq, 1'b0);
      repeat (40) @(negedge clk);
      rd(ADDR_XDATA, 8'(shadow[0]));
    end
    // shake limit, orientation, front/back and tap sources
    wr(ADDR_RATE_CFG, 8'h00);  // tap use needs the 120/s code
    wr(ADDR_IRQ_SETUP, 8'h27);
    axes = {6'd27, 12'h000};
    wr(ADDR_MODE_CTRL, 8'h01);
    wait_tick();
    wait_tick();
    check(tap_en, 1'b1);
    rd(ADDR_IRQ_STAT, 8'h00);
    axes = {6'd28, 12'h000};
    wait_tick();
    wait_tick();
    rd(ADDR_IRQ_STAT, 8'h20);
    axes = '0;
    host_inst.access(1'b0, ADDR_IRQ_STAT, 8'h00, r, k);
    {orient, fb, tap} = 3'b100;
    @(negedge clk);
    {orient, fb, tap} = 3'b010;
    @(negedge clk);
    {orient, fb, tap} = 3'b001;
    @(negedge clk);
    tap = 1'b0;
    repeat (2) @(negedge clk);
    rd(ADDR_IRQ_STAT, 8'h07);
    // auto-sleep into the low rate, then wake on orientation change
    wr(ADDR_MODE_CTRL, 8'h00);
    wr(ADDR_IRQ_SETUP, 8'h0A);
    wr(ADDR_MODE_CTRL, 8'h19);
    n = 0;
    while (pstate !== ST_DOZE && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(pstate, ST_DOZE);
    check(tap_en, 1'b0);
    wait_tick();
    wait_tick();
    check(16'(n), 16'(BASE * 2));
    rd(ADDR_IRQ_STAT, 8'h08);
    orient = 1'b1;
    @(negedge clk);
    orient = 1'b0;
    repeat (3) @(negedge clk);
    check(pstate, ST_RUN);
    complete_run();
  end
endmodule
`default_nettype wire
